// ### hw/bus_if_params.svh
`ifndef BUS_IF_PARAMS_SVH
`define BUS_IF_PARAMS_SVH

// Register byte offsets
`define REG_CTRL 12'h000
`define REG_CMD_ADDR 12'h004
`define REG_CMD_DATA 12'h008
`define REG_STATUS 12'h00c
`define REG_IRQ_STAT 12'h010
`define REG_IRQ_MASK 12'h014
`define REG_RD_DATA 12'h018
`define REG_IRQ_LEVEL 12'h01c

// Control fields
`define CTRL_GO 0
`define CTRL_WRITE 1
`define CTRL_SIZE 2
`define CTRL_IACK 3
`define CTRL_SUPER 4
`define CTRL_PROG 5
`define CTRL_LOWPWR 6
`define CTRL_IMASK_LO 8
`define CTRL_IMASK_HI 10

// Event bits
`define EV_DONE 0
`define EV_BUS_ERROR_IN 1
`define EV_IRQ 2
`define EV_GRANT 3

`define CTRL_RESET 32'h0000_0000
`define MASK_RESET 4'h0
`define IACK_LEVEL_RESET 3'h0

`endif

// ### hw/bus_if_pkg.sv
package bus_if_pkg;
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_STROBE,
		ST_WAIT,
		ST_END,
		ST_RELEASED
	} bus_state_t;

	typedef struct packed {
		logic [23:0] addr;
		logic [15:0] data;
		logic write;
		logic byte_size;
		logic iack;
		logic [2:0] space;
	} bus_cmd_t;

	typedef struct packed {
		logic [23:0] out;
		logic oe;
	} addr_pins_t;
endpackage

// ### hw/cpu_async_bus_interface.sv
// Summary of operation
// - Drive a three-state 24-bit address bus spanning 16 Mbytes on normal cycles.
// - Interrupt acknowledge puts level on address lines 3..1, all others high.
// - A static width-select input fixes the data bus at 8 or 16 bits.
// - Address strobe is asserted only while a valid address is driven.
// - Read/write line marks direction; upper and lower strobes gate data flow.
// - Bus grant answers a request; bus released after the current cycle.
// - Three encoded priority inputs present the pending level; seven levels seen.
// - Level 7 is highest priority and never masked.
// - Autovector input during acknowledge makes the vector from the level.
// - Three active-high three-state function code outputs give mode and space.
// - Function codes are valid throughout every address strobe interval.
// - Reset and halt inputs stop the block; bus error ends a failed access.
// - Low-power mode keeps all internal state while activity stops.
// - Fully static: all state is in flip-flops and survives a stopped clock.
//
// Our own choices: the AXI4-Lite register port and the placing of the registers.
`include "bus_if_params.svh"
`timescale 1ns/1ps
`default_nettype none

module cpu_async_bus_interface (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite register port
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic irq,
	// External address and data bus
	output logic [23:0] address_lines,
	output logic address_lines_oe,
	input wire logic [15:0] data_lines_in,
	output logic [15:0] data_lines_out,
	output logic data_lines_oe,
	// Bus control
	output logic addr_strobe_n,
	output logic read_write,
	output logic upper_byte_strobe_n,
	output logic lower_byte_strobe_n,
	output logic [2:0] space_code_out,
	output logic control_oe,
	input wire logic transfer_ack_n,
	input wire logic bus_error_in,
	input wire logic halt_n,
	input wire logic width_sel_16,
	// Arbitration
	input wire logic bus_request_n,
	output logic bus_grant_n,
	// Interrupts
	input wire logic [2:0] irq_priority_code,
	input wire logic auto_vector_req,
	// Status
	output logic low_power
);
	import bus_if_pkg::*;

	bus_state_t state;
	bus_cmd_t cmd;
	logic [31:0] ctrl;
	logic [3:0] irq_stat;
	logic [3:0] irq_mask;
	logic [15:0] rd_data;
	logic [7:0] vector;
	logic [2:0] iack_level;
	logic aw_hold, w_hold;
	logic [11:0] aw_addr;
	logic [31:0] w_data;
	logic cycle_bus_error_in;

	// Bus slave decode
	wire do_write = aw_hold && w_hold && !s_axi_bvalid;
	wire do_read = s_axi_arvalid && !s_axi_rvalid;
	wire wr_ctrl = do_write && aw_addr == `REG_CTRL;
	wire wr_addr = do_write && aw_addr == `REG_CMD_ADDR;
	wire wr_data = do_write && aw_addr == `REG_CMD_DATA;
	wire wr_stat = do_write && aw_addr == `REG_IRQ_STAT;
	wire wr_mask = do_write && aw_addr == `REG_IRQ_MASK;
	wire wr_hit = wr_ctrl | wr_addr | wr_data | wr_stat | wr_mask;
	wire rd_hit = s_axi_araddr == `REG_CTRL || s_axi_araddr == `REG_CMD_ADDR ||
		s_axi_araddr == `REG_CMD_DATA || s_axi_araddr == `REG_STATUS ||
		s_axi_araddr == `REG_IRQ_STAT || s_axi_araddr == `REG_IRQ_MASK ||
		s_axi_araddr == `REG_RD_DATA || s_axi_araddr == `REG_IRQ_LEVEL;

	// Core side
	wire halted = !halt_n;
	wire sleeping = ctrl[`CTRL_LOWPWR];
	wire [2:0] imask = ctrl[`CTRL_IMASK_HI:`CTRL_IMASK_LO];
	wire irq_pending = irq_priority_code == 3'h7 || irq_priority_code > imask;
	wire go = wr_ctrl && w_data[`CTRL_GO] && state == ST_IDLE && !halted && !sleeping;
	wire ack_seen = !transfer_ack_n || bus_error_in || (cmd.iack && auto_vector_req);
	wire req = !bus_request_n;
	wire word_mode = width_sel_16 && !w_data[`CTRL_SIZE];
	wire [23:0] iack_addr = {20'hfffff, irq_priority_code, 1'b1};
	wire [7:0] auto_vec = 8'h18 + {5'h00, cmd.addr[3:1]};
	wire [3:0] events;
	assign events[`EV_DONE] = state == ST_WAIT && ack_seen && !bus_error_in;
	assign events[`EV_BUS_ERROR_IN] = state == ST_WAIT && bus_error_in;
	assign events[`EV_IRQ] = irq_pending && irq_priority_code != 3'h0;
	// Both ways onto the released bus raise the event, from idle as well as after a cycle
	assign events[`EV_GRANT] = (state == ST_IDLE || state == ST_END) && req && !bus_grant_n;
	wire [3:0] clear_bits = wr_stat ? w_data[3:0] : 4'h0;
	// Set wins over a simultaneous clear
	wire [3:0] next_irq_stat = (irq_stat & ~clear_bits) | events;
	wire [15:0] byte_data = cmd.addr[0] ? {8'h00, data_lines_in[7:0]} : {8'h00, data_lines_in[15:8]};
	wire [15:0] next_rd_data = cmd.byte_size ? byte_data : data_lines_in;
	wire [31:0] status_word = {22'h000000, low_power, !bus_grant_n, cycle_bus_error_in, halted,
		irq_pending, state == ST_RELEASED, state != ST_IDLE && state != ST_RELEASED, 3'h0};

	logic [31:0] rd_mux;
	always_comb begin
		case (s_axi_araddr)
			`REG_CTRL: rd_mux = ctrl;
			`REG_CMD_ADDR: rd_mux = {8'h00, cmd.addr};
			`REG_CMD_DATA: rd_mux = {16'h0000, cmd.data};
			`REG_STATUS: rd_mux = status_word;
			`REG_IRQ_STAT: rd_mux = {28'h0000000, irq_stat};
			`REG_IRQ_MASK: rd_mux = {28'h0000000, irq_mask};
			`REG_RD_DATA: rd_mux = {16'h0000, rd_data};
			`REG_IRQ_LEVEL: rd_mux = {21'h000000, iack_level, vector};
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	// Write address and data are taken in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold <= 1'b0;
			w_hold <= 1'b0;
			aw_addr <= 12'h000;
			w_data <= 32'h0000_0000;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold <= 1'b1;
				w_data <= s_axi_wdata;
			end
			if (do_write) begin
				aw_hold <= 1'b0;
				w_hold <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_hit ? 2'h0 : 2'h2;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= 2'h0;
		end else begin
			s_axi_awready <= !aw_hold && !(s_axi_awvalid && s_axi_awready);
			s_axi_wready <= !w_hold && !(s_axi_wvalid && s_axi_wready);
			s_axi_arready <= do_read && !s_axi_arready;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_mux;
				s_axi_rresp <= rd_hit ? 2'h0 : 2'h2;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// Software registers; all state stays in place while sleeping or halted
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl <= `CTRL_RESET;
			irq_mask <= `MASK_RESET;
			irq_stat <= 4'h0;
			cmd <= '0;
		end else begin
			irq_stat <= next_irq_stat;
			if (wr_ctrl)
				ctrl <= {w_data[31:1], 1'b0};
			if (wr_mask)
				irq_mask <= w_data[3:0];
			if (wr_addr && state == ST_IDLE)
				cmd.addr <= w_data[23:0];
			if (wr_data && state == ST_IDLE)
				cmd.data <= w_data[15:0];
			if (go) begin
				cmd.write <= w_data[`CTRL_WRITE];
				cmd.byte_size <= !word_mode;
				cmd.iack <= w_data[`CTRL_IACK];
				cmd.space <= w_data[`CTRL_IACK] ? 3'h7 :
					{w_data[`CTRL_SUPER], w_data[`CTRL_PROG], !w_data[`CTRL_PROG]};
				if (w_data[`CTRL_IACK])
					cmd.addr <= iack_addr;
			end
		end
	end

	// External bus sequencer; halt and sleep only block go, so a cycle already running completes
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= ST_IDLE;
			address_lines <= 24'h000000;
			address_lines_oe <= 1'b0;
			data_lines_out <= 16'h0000;
			data_lines_oe <= 1'b0;
			addr_strobe_n <= 1'b1;
			read_write <= 1'b1;
			upper_byte_strobe_n <= 1'b1;
			lower_byte_strobe_n <= 1'b1;
			space_code_out <= 3'h0;
			control_oe <= 1'b0;
			bus_grant_n <= 1'b1;
			rd_data <= 16'h0000;
			vector <= 8'h00;
			iack_level <= `IACK_LEVEL_RESET;
			cycle_bus_error_in <= 1'b0;
			low_power <= 1'b0;
			irq <= 1'b0;
		end else begin
			irq <= |(next_irq_stat & irq_mask);
			low_power <= sleeping;
			if (req && bus_grant_n)
				bus_grant_n <= 1'b0;
			// A request withdrawn before the release must not leave the grant stuck low
			else if (!req && !bus_grant_n)
				bus_grant_n <= 1'b1;
			case (state)
				ST_IDLE: begin
					if (req && !bus_grant_n) begin
						state <= ST_RELEASED;
						address_lines_oe <= 1'b0;
						data_lines_oe <= 1'b0;
						control_oe <= 1'b0;
					end else if (go) begin
						state <= ST_STROBE;
						address_lines <= w_data[`CTRL_IACK] ? iack_addr : cmd.addr;
						address_lines_oe <= 1'b1;
						control_oe <= 1'b1;
						read_write <= !w_data[`CTRL_WRITE] || w_data[`CTRL_IACK];
						space_code_out <= w_data[`CTRL_IACK] ? 3'h7 :
							{w_data[`CTRL_SUPER], w_data[`CTRL_PROG], !w_data[`CTRL_PROG]};
						data_lines_out <= cmd.data;
						data_lines_oe <= w_data[`CTRL_WRITE] && !w_data[`CTRL_IACK];
						cycle_bus_error_in <= 1'b0;
					end
				end
				ST_STROBE: begin
					// Address and codes settled a cycle earlier, so the strobe marks a valid address
					state <= ST_WAIT;
					addr_strobe_n <= 1'b0;
					upper_byte_strobe_n <= cmd.byte_size && cmd.addr[0];
					lower_byte_strobe_n <= cmd.byte_size && !cmd.addr[0];
				end
				ST_WAIT: begin
					if (ack_seen) begin
						state <= ST_END;
						addr_strobe_n <= 1'b1;
						upper_byte_strobe_n <= 1'b1;
						lower_byte_strobe_n <= 1'b1;
						cycle_bus_error_in <= bus_error_in;
						if (!cmd.write && !cmd.iack)
							rd_data <= next_rd_data;
						if (cmd.iack) begin
							iack_level <= cmd.addr[3:1];
							vector <= auto_vector_req ? auto_vec : data_lines_in[7:0];
						end
					end
				end
				ST_END: begin
					data_lines_oe <= 1'b0;
					read_write <= 1'b1;
					if (req && !bus_grant_n) begin
						state <= ST_RELEASED;
						address_lines_oe <= 1'b0;
						control_oe <= 1'b0;
					end else
						state <= ST_IDLE;
				end
				ST_RELEASED: begin
					if (!req) begin
						state <= ST_IDLE;
						bus_grant_n <= 1'b1;
					end
				end
				default: state <= ST_IDLE;
			endcase
		end
	end
endmodule // cpu_async_bus_interface

`default_nettype wire

// ### verif/bus_slave_model.sv
`timescale 1ns/1ps
`default_nettype none

module bus_slave_model (
	// Bus side
	input wire logic aclk,
	input wire logic addr_strobe_n,
	input wire logic read_write,
	input wire logic [23:0] address_lines,
	input wire logic [2:0] space_code_out,
	input wire logic [15:0] data_lines_out,
	output logic [15:0] data_lines_in,
	output logic transfer_ack_n,
	output logic bus_error_in,
	output logic auto_vector_req,
	// Behaviour set by the bench
	input wire logic [1:0] mode,
	input wire logic [3:0] delay,
	input wire logic [15:0] rd_word,
	output logic [15:0] wr_word,
	output logic [23:0] seen_addr
);
	logic [3:0] cnt = 4'h0;
	logic hit;
	// Answer holds until the strobe rises, as a real slave does
	assign hit = !addr_strobe_n && cnt >= delay;
	assign transfer_ack_n = !(hit && mode == 2'h0);
	assign bus_error_in = hit && mode == 2'h1;
	assign auto_vector_req = hit && mode == 2'h2 && space_code_out == 3'h7;
	// Outside the answer the lines show the inverse, so stale data cannot pass
	assign data_lines_in = (hit && read_write) ? rd_word : ~rd_word;
	always @(posedge aclk) begin
		cnt <= addr_strobe_n ? 4'h0 : (hit ? cnt : cnt + 4'h1);
		if (hit)
			seen_addr <= address_lines;
		if (hit && !read_write)
			wr_word <= data_lines_out;
	end
endmodule // bus_slave_model

`default_nettype wire

// ### verif/cpu_async_bus_interface_properties.sv
`timescale 1ns/1ps
`default_nettype none

module bus_if_checker (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Bus pins
	input wire logic [23:0] address_lines,
	input wire logic address_lines_oe,
	input wire logic data_lines_oe,
	input wire logic addr_strobe_n,
	input wire logic read_write,
	input wire logic upper_byte_strobe_n,
	input wire logic lower_byte_strobe_n,
	input wire logic [2:0] space_code_out,
	input wire logic control_oe,
	input wire logic transfer_ack_n,
	input wire logic bus_error_in,
	input wire logic auto_vector_req,
	input wire logic bus_request_n,
	input wire logic bus_grant_n
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	logic iack;
	assign iack = space_code_out == 3'h7;
	a_strobe_addr: assert property (!addr_strobe_n |-> address_lines_oe && control_oe)
		else $error("strobe without driven address");
	a_data_strobes: assert property (addr_strobe_n |-> upper_byte_strobe_n && lower_byte_strobe_n)
		else $error("data strobe outside address strobe");
	a_wait_ack: assert property (!addr_strobe_n && transfer_ack_n && !bus_error_in && !auto_vector_req |=> !addr_strobe_n)
		else $error("cycle ended without answer");
	a_end_ack: assert property (!addr_strobe_n && !transfer_ack_n |-> ##[1:2] addr_strobe_n)
		else $error("cycle not ended after answer");
	a_codes_hold: assert property (!addr_strobe_n && !$past(addr_strobe_n) |-> $stable(space_code_out) && $stable(address_lines))
		else $error("codes moved under strobe");
	a_iack_addr: assert property (!addr_strobe_n && iack |-> address_lines[23:4] == 20'hfffff && address_lines[0])
		else $error("acknowledge address wrong");
	a_data_dir: assert property (!addr_strobe_n && !iack |-> data_lines_oe == !read_write)
		else $error("data drive against direction");
	a_byte_lane: assert property (!addr_strobe_n && !iack && upper_byte_strobe_n != lower_byte_strobe_n |-> address_lines[0] == !lower_byte_strobe_n)
		else $error("byte strobe on wrong lane");
	a_grant_reply: assert property ($fell(bus_request_n) |=> !bus_grant_n)
		else $error("no grant after request");
	a_bus_float: assert property ((!bus_grant_n && addr_strobe_n) [*3] |-> !address_lines_oe && !control_oe && !data_lines_oe)
		else $error("bus driven while granted");
endmodule // bus_if_checker

bind cpu_async_bus_interface bus_if_checker bus_if_checker_i (.*);

`default_nettype wire

// ### verif/cpu_async_bus_interface_tb.sv
`include "bus_if_params.svh"
`timescale 1ns/1ps
`default_nettype none

module cpu_async_bus_interface_tb;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq, low_power;
	logic [1:0] s_axi_bresp, s_axi_rresp, wresp;
	logic [23:0] address_lines, seen_addr;
	logic [15:0] data_lines_in, data_lines_out, wr_word;
	logic address_lines_oe, data_lines_oe, addr_strobe_n, read_write, control_oe, bus_grant_n;
	logic upper_byte_strobe_n, lower_byte_strobe_n, transfer_ack_n, bus_error_in, auto_vector_req;
	logic [2:0] space_code_out, irq_priority_code = 3'h0;
	logic halt_n = 1'b1, width_sel_16 = 1'b1, bus_request_n = 1'b1;
	logic [1:0] mode = 2'h0;
	logic [3:0] delay = 4'h2;
	logic [15:0] rd_word = 16'h0;
	int num_errors = 0, samples_checked = 0, cycles = 0;
	cpu_async_bus_interface cpu_async_bus_interface_i (.*);
	bus_slave_model bus_slave_model_i (.*);
	initial begin
		forever #50 aclk = ~aclk;
	end
	task automatic print_verdict();
		if (num_errors == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	always @(posedge aclk) begin
		cycles++;
		// Whole run needs a few hundred cycles
		if (cycles == 20000) begin
			num_errors++;
			print_verdict();
		end
	end
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		samples_checked++;
		if (s !== e) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic ap, dp;
		ap = 1'b1;
		dp = 1'b1;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready)
				ap = 1'b0;
			if (s_axi_wready)
				dp = 1'b0;
			s_axi_awvalid <= ap;
			s_axi_wvalid <= dp;
		end while (ap || dp);
		while (!s_axi_bvalid) @(posedge aclk);
		wresp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		while (!s_axi_rvalid) @(posedge aclk);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	task automatic rc(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
		logic [31:0] v;
		logic [1:0] r;
		rd(a, v, r);
		chk("rdata", e, v);
		chk("rresp", {30'h0, er}, {30'h0, r});
	endtask
	task automatic go(input logic [23:0] a, input logic [15:0] d, input logic [31:0] c);
		logic [31:0] v;
		logic [1:0] r;
		wr(`REG_CMD_ADDR, {8'h0, a});
		wr(`REG_CMD_DATA, {16'h0, d});
		wr(`REG_CTRL, c | 32'h1);
		do rd(`REG_STATUS, v, r); while (v[3]);
	endtask
	task automatic t_regs();
		rc(`REG_CTRL, `CTRL_RESET, 2'h0);
		rc(`REG_IRQ_MASK, 32'h0, 2'h0);
		rc(12'h100, 32'h0, 2'h2);
		wr(12'h100, 32'h1);
		chk("bresp", 32'h2, {30'h0, wresp});
	endtask
	task automatic t_words();
		rd_word <= 16'ha55a;
		delay <= 4'h5;
		wr(`REG_IRQ_STAT, 32'hf);
		go(24'h123456, 16'h0, 32'h10);
		rc(`REG_RD_DATA, 32'ha55a, 2'h0);
		chk("addr", 32'h123456, {8'h0, seen_addr});
		rc(`REG_IRQ_STAT, 32'h1, 2'h0);
		wr(`REG_IRQ_STAT, 32'h1);
		rc(`REG_IRQ_STAT, 32'h0, 2'h0);
		go(24'h000100, 16'hbeef, 32'h2);
		chk("word write", 32'hbeef, {16'h0, wr_word});
	endtask
	task automatic t_bytes();
		delay <= 4'h0;
		go(24'h000021, 16'h00c3, 32'h6);
		chk("odd byte", 32'hc3, {24'h0, wr_word[7:0]});
		rd_word <= 16'h7e81;
		go(24'h000040, 16'h0, 32'h4);
		rc(`REG_RD_DATA, 32'h7e, 2'h0);
	endtask
	task automatic t_bus_error_in();
		mode <= 2'h1;
		wr(`REG_IRQ_MASK, 32'h2);
		go(24'h000200, 16'h0, 32'h0);
		repeat (2) @(posedge aclk);
		chk("irq set", 32'h1, {31'h0, irq});
		wr(`REG_IRQ_MASK, 32'h0);
		repeat (2) @(posedge aclk);
		chk("irq masked", 32'h0, {31'h0, irq});
		wr(`REG_IRQ_MASK, 32'h2);
		wr(`REG_IRQ_STAT, 32'hf);
		repeat (2) @(posedge aclk);
		chk("irq cleared", 32'h0, {31'h0, irq});
		mode <= 2'h0;
	endtask
	task automatic t_iack();
		mode <= 2'h2;
		irq_priority_code <= 3'h5;
		go(24'h0, 16'h0, 32'h8);
		rc(`REG_IRQ_LEVEL, 32'h51d, 2'h0);
		chk("iack addr", 32'hfffffb, {8'h0, seen_addr});
		mode <= 2'h0;
	endtask
	task automatic t_level();
		irq_priority_code <= 3'h3;
		wr(`REG_CTRL, 32'h700);
		wr(`REG_IRQ_STAT, 32'hf);
		rc(`REG_IRQ_STAT, 32'h0, 2'h0);
		irq_priority_code <= 3'h7;
		wr(`REG_IRQ_STAT, 32'hf);
		rc(`REG_IRQ_STAT, 32'h4, 2'h0);
		irq_priority_code <= 3'h0;
		wr(`REG_CTRL, 32'h0);
		wr(`REG_IRQ_STAT, 32'hf);
	endtask
	task automatic t_grant();
		bus_request_n <= 1'b0;
		repeat (4) @(posedge aclk);
		chk("grant", 32'h0, {31'h0, bus_grant_n});
		chk("float", 32'h0, {30'h0, address_lines_oe, control_oe});
		bus_request_n <= 1'b1;
		repeat (4) @(posedge aclk);
		chk("grant off", 32'h1, {31'h0, bus_grant_n});
		rc(`REG_IRQ_STAT, 32'h8, 2'h0);
	endtask
	task automatic t_quiet();
		halt_n <= 1'b0;
		wr(`REG_IRQ_STAT, 32'hf);
		wr(`REG_CTRL, 32'h1);
		rc(`REG_STATUS, 32'h40, 2'h0);
		halt_n <= 1'b1;
		wr(`REG_CTRL, 32'h40);
		repeat (2) @(posedge aclk);
		chk("low power", 32'h1, {31'h0, low_power});
		wr(`REG_CTRL, 32'h41);
		rc(`REG_STATUS, 32'h200, 2'h0);
		wr(`REG_CTRL, 32'h0);
		rc(`REG_IRQ_STAT, 32'h0, 2'h0);
	endtask
	task automatic t_narrow();
		// Width select only moves while reset is held, so it stays static in operation
		aresetn <= 1'b0;
		width_sel_16 <= 1'b0;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		rc(`REG_CTRL, `CTRL_RESET, 2'h0);
		rd_word <= 16'h7e81;
		go(24'h000041, 16'h0, 32'h0);
		rc(`REG_RD_DATA, 32'h81, 2'h0);
	endtask
	initial begin
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		t_regs();
		t_words();
		t_bytes();
		t_bus_error_in();
		t_iack();
		t_level();
		t_grant();
		t_quiet();
		t_narrow();
		print_verdict();
	end
endmodule // cpu_async_bus_interface_tb

`default_nettype wire
